//--- rtl/async_serial_transceiver.sv
/*
 * asynchronous serial transmitter and receiver with fractional baud generator and fifos.
 * assumes a plain register port (read data one cycle after the read strobe) and a serial input
 * already synchronous to i_sys_clk.
 */
`timescale 1ns/1ps
`include "uart_map.svh"

// How it works
// RULE1: start, data lsb first, parity, stop bits
// RULE2: receiver flags overrun, parity, framing, break per character
// RULE3: two sixteen-entry fifos, four status bits
// RULE4: divisor is 16 integer plus 6 fraction
// RULE5: divisor equals clock over sixteen times baud
// RULE6: sixteen-times tick paces both directions
// RULE7: divisor loads only on line-control write
// RULE8: separate direction enables, both on after reset
// RULE9: software disables before reprogramming control
// RULE10: disable lets current character finish
// RULE11: fifo write starts back-to-back transmission
// RULE12: busy until fifo empty and stop sent
// RULE13: start checked on eighth tick, else error
// RULE14: data sampled every sixteenth tick
// RULE15: parity sampled right after last data
// RULE16: low stop sample raises framing error
// RULE17: five to eight data bits
// RULE18: even, odd, stick or no parity
// RULE19: one or two stop bits
// RULE20: break driven on transmit, detected on receive
// RULE21: fifo thresholds at eighths of depth
// RULE22: fifos can run one entry deep
// RULE23: fifos single-entry after reset until enabled
// RULE24: break is low for whole character
module async_serial_transceiver #(
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// serial line
	input wire logic i_serial_in,
	output logic o_serial_out,
	// status
	output logic o_busy,
	output logic o_tx_level_hit,
	output logic o_rx_level_hit
);
	localparam int CW = $clog2(DEPTH+1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_bad_depth
		$error("DEPTH must be a power of two of at least 2");
	end

	logic [9:0] control_reg;
	logic [15:0] divisor_integer_reg;
	logic [5:0] divisor_fraction_reg;
	logic [7:0] line_control_reg;
	logic [21:0] divisor_value_reg;
	logic [5:0] level_sel_reg;
	logic [4:0] receive_status_reg;
	logic [22:0] acc_reg;
	logic oversample_tick;
	logic [22:0] acc_sum;
	uart_pkg::frame_state_e tx_state_reg;
	logic [3:0] tx_tick_reg;
	logic [2:0] tx_bit_reg;
	logic [7:0] tx_shift_reg;
	logic tx_par_reg;
	logic tx_stop_first_reg;
	logic tx_line;
	uart_pkg::frame_state_e rx_state_reg;
	logic [3:0] rx_tick_reg;
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_shift_reg;
	logic rx_in_reg;
	logic rx_idle_ok_reg;
	logic rx_zero_reg;
	logic rx_pe_reg;
	logic rx_oe_pend_reg;
	logic rx_push_ev;
	logic [11:0] rx_push_data;
	logic global_enable;
	logic tx_enable;
	logic rx_enable;
	logic fifo_enable;
	logic [2:0] last_bit;
	logic tx_push;
	logic tx_pop;
	logic tx_full;
	logic tx_empty;
	logic [7:0] tx_data;
	logic [CW-1:0] tx_count;
	logic rx_pop;
	logic rx_full;
	logic rx_empty;
	logic [11:0] rx_data;
	logic [CW-1:0] rx_count;
	logic rsr_clear;

	function automatic logic parity_of(input logic [7:0] data, input logic [7:0] lcr);
		logic [7:0] mask;
		logic p;
		mask = 8'hff >> (2'h3 - lcr[`LCR_WLEN]);
		p = ^(data & mask);
		if (lcr[`LCR_SPS])
			parity_of = ~lcr[`LCR_EPS]; // RULE18
		else
			parity_of = lcr[`LCR_EPS] ? p : ~p; // RULE18
	endfunction

	function automatic logic [CW-1:0] threshold(input logic [2:0] sel);
		logic [3:0] eighths;
		case (sel)
			3'h0: eighths = 4'h1;
			3'h1: eighths = 4'h2;
			3'h3: eighths = 4'h6;
			3'h4: eighths = 4'h7;
			default: eighths = 4'h4;
		endcase
		threshold = CW'(int'(eighths) * DEPTH / 8); // RULE21
	endfunction

	assign global_enable = control_reg[`CTL_EN];
	assign tx_enable = control_reg[`CTL_TXE];
	assign rx_enable = control_reg[`CTL_RXE];
	assign fifo_enable = line_control_reg[`LCR_FEN];
	assign last_bit = 3'h4 + {1'b0, line_control_reg[`LCR_WLEN]}; // RULE17
	assign tx_push = i_wr && i_addr == `OFF_DATA;
	assign rx_pop = i_rd && i_addr == `OFF_DATA;
	assign rsr_clear = i_wr && i_addr == `OFF_RSR;

	uart_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo ( // RULE3
		.i_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_deep(fifo_enable), // RULE23
		.i_push(tx_push),
		.i_data(i_wdata[7:0]),
		.o_full(tx_full),
		.i_pop(tx_pop),
		.o_data(tx_data),
		.o_empty(tx_empty),
		.o_count(tx_count)
	);

	uart_fifo #(.WIDTH(12), .DEPTH(DEPTH)) u_rx_fifo ( // RULE3
		.i_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_deep(fifo_enable), // RULE23
		.i_push(rx_push_ev),
		.i_data(rx_push_data),
		.o_full(rx_full),
		.i_pop(rx_pop),
		.o_data(rx_data),
		.o_empty(rx_empty),
		.o_count(rx_count)
	);

	// configuration registers
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			control_reg <= `CTL_RESET; // RULE8
			divisor_integer_reg <= 16'h0000;
			divisor_fraction_reg <= 6'h00;
			line_control_reg <= 8'h00; // RULE23
			divisor_value_reg <= 22'h000000;
			level_sel_reg <= `LVL_RESET;
		end
		else if (i_wr)
		begin
			case (i_addr)
				`OFF_CTL: control_reg <= {i_wdata[9:8], 7'h00, i_wdata[0]};
				`OFF_IBRD: divisor_integer_reg <= i_wdata[15:0];
				`OFF_FBRD: divisor_fraction_reg <= i_wdata[5:0];
				`OFF_LCR:
				begin
					line_control_reg <= i_wdata[7:0];
					divisor_value_reg <= {divisor_integer_reg, divisor_fraction_reg}; // RULE7
				end
				`OFF_LVL: level_sel_reg <= i_wdata[5:0];
				default: ;
			endcase
		end
	end

	// fractional baud generator: 64 per clock against a divisor in 1/64ths
	assign acc_sum = acc_reg + `FRAC_ONE;

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn || divisor_value_reg[21:6] == 16'h0000)
		begin
			acc_reg <= 23'h000000;
			oversample_tick <= 1'b0;
		end
		else if (acc_sum >= {1'b0, divisor_value_reg}) // RULE4 RULE5
		begin
			acc_reg <= acc_sum - {1'b0, divisor_value_reg};
			oversample_tick <= 1'b1; // RULE6
		end
		else
		begin
			acc_reg <= acc_sum;
			oversample_tick <= 1'b0;
		end
	end

	// transmitter
	assign tx_pop = tx_state_reg == uart_pkg::ST_IDLE && global_enable && tx_enable && !tx_empty; // RULE11 RULE8

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			tx_state_reg <= uart_pkg::ST_IDLE;
			tx_tick_reg <= 4'h0;
			tx_bit_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
			tx_stop_first_reg <= 1'b0;
		end
		else if (tx_pop)
		begin
			tx_state_reg <= uart_pkg::ST_START;
			tx_tick_reg <= 4'h0;
			tx_shift_reg <= tx_data;
			tx_par_reg <= parity_of(tx_data, line_control_reg);
		end
		else if (oversample_tick && tx_state_reg != uart_pkg::ST_IDLE)
		begin
			tx_tick_reg <= tx_tick_reg + 4'h1;
			if (tx_tick_reg == `LAST_TICK) // RULE6
			begin
				unique case (tx_state_reg)
					uart_pkg::ST_START:
					begin
						tx_state_reg <= uart_pkg::ST_DATA;
						tx_bit_reg <= 3'h0;
					end
					uart_pkg::ST_DATA:
					begin
						tx_shift_reg <= {1'b0, tx_shift_reg[7:1]}; // RULE1
						tx_bit_reg <= tx_bit_reg + 3'h1;
						if (tx_bit_reg == last_bit)
						begin
							tx_state_reg <= line_control_reg[`LCR_PEN] ? uart_pkg::ST_PARITY : uart_pkg::ST_STOP;
							tx_stop_first_reg <= line_control_reg[`LCR_STP2];
						end
					end
					uart_pkg::ST_PARITY: tx_state_reg <= uart_pkg::ST_STOP;
					uart_pkg::ST_STOP:
					begin
						tx_stop_first_reg <= 1'b0;
						if (!tx_stop_first_reg) // RULE19
							tx_state_reg <= uart_pkg::ST_IDLE; // RULE10
					end
					uart_pkg::ST_IDLE: ;
				endcase
			end
		end
	end

	always_comb
	begin
		unique case (tx_state_reg)
			uart_pkg::ST_START: tx_line = 1'b0;
			uart_pkg::ST_DATA: tx_line = tx_shift_reg[0];
			uart_pkg::ST_PARITY: tx_line = tx_par_reg;
			uart_pkg::ST_STOP: tx_line = 1'b1;
			uart_pkg::ST_IDLE: tx_line = 1'b1;
			default: tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			o_serial_out <= 1'b1;
			o_busy <= 1'b0;
		end
		else
		begin
			o_serial_out <= tx_line && !line_control_reg[`LCR_BRK]; // RULE1 RULE20
			o_busy <= !tx_empty || tx_state_reg != uart_pkg::ST_IDLE; // RULE12
		end
	end

	// receiver
	assign rx_push_ev = rx_state_reg == uart_pkg::ST_STOP && oversample_tick && rx_tick_reg == `LAST_TICK;
	assign rx_push_data = {rx_oe_pend_reg, rx_zero_reg && !rx_in_reg, rx_pe_reg, !rx_in_reg, rx_shift_reg}; // RULE2 RULE16 RULE24

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			rx_in_reg <= 1'b1;
			rx_state_reg <= uart_pkg::ST_IDLE;
			rx_tick_reg <= 4'h0;
			rx_bit_reg <= 3'h0;
			rx_shift_reg <= 8'h00;
			rx_idle_ok_reg <= 1'b0;
			rx_zero_reg <= 1'b0;
			rx_pe_reg <= 1'b0;
		end
		else
		begin
			rx_in_reg <= i_serial_in;
			if (rx_state_reg == uart_pkg::ST_IDLE)
			begin
				if (rx_in_reg)
					rx_idle_ok_reg <= 1'b1;
				else if (rx_idle_ok_reg && global_enable && rx_enable) // RULE13 RULE8
				begin
					rx_state_reg <= uart_pkg::ST_START;
					rx_tick_reg <= 4'h0;
					rx_idle_ok_reg <= 1'b0;
				end
			end
			else if (oversample_tick)
			begin
				rx_tick_reg <= rx_tick_reg + 4'h1;
				unique case (rx_state_reg)
					uart_pkg::ST_START:
					begin
						if (rx_tick_reg == `START_SAMPLE) // RULE13
						begin
							rx_tick_reg <= 4'h0;
							rx_bit_reg <= 3'h0;
							rx_shift_reg <= 8'h00;
							rx_zero_reg <= 1'b1;
							rx_pe_reg <= 1'b0;
							rx_state_reg <= rx_in_reg ? uart_pkg::ST_IDLE : uart_pkg::ST_DATA;
						end
					end
					uart_pkg::ST_DATA:
					begin
						if (rx_tick_reg == `LAST_TICK) // RULE14
						begin
							rx_shift_reg[rx_bit_reg] <= rx_in_reg;
							rx_zero_reg <= rx_zero_reg && !rx_in_reg;
							rx_bit_reg <= rx_bit_reg + 3'h1;
							if (rx_bit_reg == last_bit) // RULE17
								rx_state_reg <= line_control_reg[`LCR_PEN] ? uart_pkg::ST_PARITY : uart_pkg::ST_STOP;
						end
					end
					uart_pkg::ST_PARITY:
					begin
						if (rx_tick_reg == `LAST_TICK) // RULE15
						begin
							rx_pe_reg <= rx_in_reg != parity_of(rx_shift_reg, line_control_reg); // RULE18
							rx_zero_reg <= rx_zero_reg && !rx_in_reg; // RULE24
							rx_state_reg <= uart_pkg::ST_STOP;
						end
					end
					uart_pkg::ST_STOP:
					begin
						if (rx_tick_reg == `LAST_TICK) // RULE10
							rx_state_reg <= uart_pkg::ST_IDLE;
					end
					uart_pkg::ST_IDLE: ;
				endcase
			end
		end
	end

	// overrun: a full fifo drops the character and tags the next stored one
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
			rx_oe_pend_reg <= 1'b0;
		else if (rx_push_ev)
			rx_oe_pend_reg <= rx_full; // RULE2
	end

	// receive status: hardware set wins over software clear
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
			receive_status_reg <= 5'h00;
		else
		begin
			if (rsr_clear)
				receive_status_reg <= 5'h00;
			if (rx_push_ev)
			begin
				if (rx_full)
					receive_status_reg[`RSR_OE] <= 1'b1; // RULE2
				if (!rx_in_reg)
					receive_status_reg[`RSR_FE] <= 1'b1; // RULE16
				if (rx_pe_reg)
					receive_status_reg[`RSR_PE] <= 1'b1;
				if (rx_zero_reg && !rx_in_reg)
					receive_status_reg[`RSR_BE] <= 1'b1; // RULE20
			end
			if (rx_state_reg == uart_pkg::ST_START && oversample_tick && rx_tick_reg == `START_SAMPLE && rx_in_reg)
				receive_status_reg[`RSR_SE] <= 1'b1; // RULE13
		end
	end

	// read data and level outputs
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rstn)
		begin
			o_rdata <= 32'h00000000;
			o_tx_level_hit <= 1'b0;
			o_rx_level_hit <= 1'b0;
		end
		else
		begin
			o_tx_level_hit <= tx_count <= threshold(level_sel_reg[2:0]); // RULE21
			o_rx_level_hit <= rx_count >= threshold(level_sel_reg[5:3]); // RULE21
			o_rdata <= 32'h00000000;
			if (i_rd)
			begin
				case (i_addr)
					`OFF_DATA: o_rdata <= {20'h00000, rx_empty ? 12'h000 : rx_data};
					`OFF_RSR: o_rdata <= {27'h0000000, receive_status_reg};
					`OFF_FLAG: o_rdata <= {24'h000000, tx_empty, rx_full, tx_full, rx_empty, o_busy, 3'h0};
					`OFF_IBRD: o_rdata <= {16'h0000, divisor_integer_reg};
					`OFF_FBRD: o_rdata <= {26'h0000000, divisor_fraction_reg};
					`OFF_LCR: o_rdata <= {24'h000000, line_control_reg};
					`OFF_CTL: o_rdata <= {22'h000000, control_reg};
					`OFF_LVL: o_rdata <= {26'h0000000, level_sel_reg};
					default: o_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	a_tx_start_low: assert property (tx_state_reg == uart_pkg::ST_START && !line_control_reg[`LCR_BRK] // RULE1
		|=> !o_serial_out) else $error("start bit not low");
	a_tx_stop_high: assert property (tx_state_reg == uart_pkg::ST_STOP && !line_control_reg[`LCR_BRK] // RULE19
		|=> o_serial_out) else $error("stop bit not high");
	a_busy_set: assert property (!tx_empty |=> o_busy) else $error("busy missing with fifo data"); // RULE12
	a_busy_clear: assert property (tx_empty && tx_state_reg == uart_pkg::ST_IDLE // RULE12
		|=> !o_busy) else $error("busy stuck after transmission");
	a_tx_hold_off: assert property (tx_state_reg == uart_pkg::ST_IDLE && !global_enable // RULE8
		|=> tx_state_reg == uart_pkg::ST_IDLE) else $error("transmit started while disabled");
	a_tx_finish: assert property (tx_state_reg != uart_pkg::ST_IDLE && !global_enable // RULE10
		&& !(tx_state_reg == uart_pkg::ST_STOP && oversample_tick && tx_tick_reg == `LAST_TICK)
		|=> tx_state_reg != uart_pkg::ST_IDLE) else $error("character cut short on disable");
	a_false_start: assert property (rx_state_reg == uart_pkg::ST_START && oversample_tick // RULE13
		&& rx_tick_reg == `START_SAMPLE && rx_in_reg
		|=> rx_state_reg == uart_pkg::ST_IDLE && receive_status_reg[`RSR_SE]) else $error("false start not flagged");
	a_frame_error: assert property (rx_push_ev && !rx_in_reg |-> rx_push_data[8] // RULE16
		##1 receive_status_reg[`RSR_FE]) else $error("framing error not recorded");
	a_div_load: assert property (i_wr && i_addr == `OFF_LCR // RULE7
		|=> divisor_value_reg[21:6] == $past(divisor_integer_reg) && divisor_value_reg[5:0] == $past(divisor_fraction_reg))
		else $error("divisor not loaded");
	a_div_hold: assert property (!(i_wr && i_addr == `OFF_LCR) // RULE7
		|=> $stable(divisor_value_reg)) else $error("divisor changed without line control write");
	a_no_tick_zero: assert property (divisor_value_reg[21:6] == 16'h0000 // RULE4
		|=> !oversample_tick) else $error("tick with zero divisor");

	c_tx_char: cover property (tx_state_reg == uart_pkg::ST_STOP ##1 tx_state_reg == uart_pkg::ST_IDLE);
	c_rx_push: cover property (rx_push_ev && !rx_full);
	c_rx_break: cover property (rx_push_ev && rx_zero_reg && !rx_in_reg);
	c_false_start: cover property (receive_status_reg[`RSR_SE]);
endmodule

//--- rtl/uart_map.svh
/*
 * register offsets, field positions, reset values and timing counts of the serial transceiver.
 * assumes byte addresses on an 8-bit register port with one 32-bit word per register.
 */
`ifndef UART_MAP_SVH
`define UART_MAP_SVH
`define OFF_DATA 8'h00
`define OFF_RSR 8'h04
`define OFF_FLAG 8'h18
`define OFF_IBRD 8'h24
`define OFF_FBRD 8'h28
`define OFF_LCR 8'h2c
`define OFF_CTL 8'h30
`define OFF_LVL 8'h34
`define LCR_BRK 0
`define LCR_PEN 1
`define LCR_EPS 2
`define LCR_STP2 3
`define LCR_FEN 4
`define LCR_WLEN 6:5
`define LCR_SPS 7
`define CTL_EN 0
`define CTL_TXE 8
`define CTL_RXE 9
`define CTL_RESET 10'h300
`define LVL_RESET 6'h12
`define RSR_FE 0
`define RSR_PE 1
`define RSR_BE 2
`define RSR_OE 3
`define RSR_SE 4
`define FLG_BUSY 3
`define FLG_RXFE 4
`define FLG_TXFF 5
`define FLG_RXFF 6
`define FLG_TXFE 7
`define FRAC_ONE 23'h40
`define START_SAMPLE 4'h7
`define LAST_TICK 4'hf
`endif

//--- rtl/uart_pkg.sv
/*
 * types shared by the serial transceiver.
 * assumes nothing of its surroundings.
 */
package uart_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PARITY = 3'b011,
		ST_STOP = 3'b100
	} frame_state_e;
endpackage

//--- rtl/uart_fifo.sv
/*
 * flip-flop fifo with a single-entry mode.
 * assumes push and pop requests are synchronous; a push when full or pop when empty is ignored.
 */
`timescale 1ns/1ps
module uart_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// mode: full depth when high, one entry when low
	input wire logic i_deep,
	// fill side
	input wire logic i_push,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_full,
	// drain side
	input wire logic i_pop,
	output logic [WIDTH-1:0] o_data,
	output logic o_empty,
	output logic [$clog2(DEPTH+1)-1:0] o_count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] cap;
	logic do_push;
	logic do_pop;

	assign cap = i_deep ? CW'(DEPTH) : CW'(1); // RULE22
	assign o_full = count_reg >= cap;
	assign o_empty = count_reg == '0;
	assign o_count = count_reg;
	assign o_data = mem_reg[rd_ptr_reg];
	assign do_push = i_push & ~o_full;
	assign do_pop = i_pop & ~o_empty;

	always_ff @(posedge i_clk)
	begin
		if (do_push)
			mem_reg[wr_ptr_reg] <= i_data;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			if (do_pop)
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			if (do_push && !do_pop)
				count_reg <= count_reg + CW'(1);
			else if (do_pop && !do_push)
				count_reg <= count_reg - CW'(1);
		end
	end

	a_single_entry: assert property (@(posedge i_clk) disable iff (!i_rstn) // RULE23
		!i_deep && !$past(i_deep) && $past(count_reg) <= CW'(1) |-> count_reg <= CW'(1))
		else $error("fifo holds more than one entry in single mode");
endmodule

//--- sim/serial_peer.sv
/*
 * remote serial peer: sends frames to the transceiver and decodes the frames it sends.
 * assumes a bit time of bit_clk system clocks, set by the bench together with the frame format.
 */
`timescale 1ns/1ps
module serial_peer (
	// clock
	input wire logic i_sys_clk,
	// line from the transceiver
	input wire logic i_line,
	// line to the transceiver, idle high
	output logic o_line
);
	int bit_clk = 16;
	int nbits = 8;
	int par_en = 0;
	logic [9:0] rx_q[$];
	realtime fall_q[$];

	initial o_line = 1'b1;

	// decode from the middle of the start bit; word is {stop, parity, data}, data lsb first
	always
	begin
		logic [9:0] rw;
		@(negedge i_line);
		fall_q.push_back($realtime);
		rw = '0;
		repeat (bit_clk / 2) @(posedge i_sys_clk);
		for (int i = 0; i < nbits + par_en + 1; i++)
		begin
			repeat (bit_clk) @(posedge i_sys_clk);
			rw[i] = i_line;
		end
		rx_q.push_back(rw);
	end

	// start bit, then n bits of fw lsb first, then one idle bit
	task automatic send(input logic [9:0] fw, input int n);
		o_line <= 1'b0;
		repeat (bit_clk) @(posedge i_sys_clk);
		for (int i = 0; i < n; i++)
		begin
			o_line <= fw[i];
			repeat (bit_clk) @(posedge i_sys_clk);
		end
		o_line <= 1'b1;
		repeat (bit_clk) @(posedge i_sys_clk);
	endtask

	// short low pulse, shorter than half a bit
	task automatic glitch(input int k);
		o_line <= 1'b0;
		repeat (k) @(posedge i_sys_clk);
		o_line <= 1'b1;
	endtask
endmodule

//--- sim/tb.sv
/*
 * self-checking bench of the serial transceiver with a remote peer on the line.
 * assumes divisor 1.0 gives one oversample tick per clock, so one bit lasts 16 clocks.
 */
`timescale 1ns/1ps
`include "uart_map.svh"
module tb;
	localparam int thr[5] = '{2, 4, 8, 12, 14};
	localparam logic [7:0] par_lcr[5] = '{8'h00, 8'h06, 8'h02, 8'h82, 8'h86};
	logic i_sys_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [31:0] o_rdata;
	logic serial_in;
	logic o_serial_out;
	logic o_busy;
	logic o_tx_level_hit;
	logic o_rx_level_hit;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;
	int dc;
	logic [9:0] w;

	async_serial_transceiver #(.DEPTH(16)) u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_in(serial_in),
		.o_serial_out(o_serial_out), .o_busy(o_busy), .o_tx_level_hit(o_tx_level_hit),
		.o_rx_level_hit(o_rx_level_hit));
	serial_peer u_peer (.i_sys_clk(i_sys_clk), .i_line(o_serial_out), .o_line(serial_in));

	initial forever #12.5 i_sys_clk = ~i_sys_clk;

	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: run hung", $time);
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		// let one edge pass with the strobe low before the next request
		@(posedge i_sys_clk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string m);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		// read data stand for this one cycle; look mid-cycle where they are settled
		@(negedge i_sys_clk);
		chk(o_rdata, exp, m);
		@(posedge i_sys_clk);
	endtask

	function automatic logic [9:0] frame(input logic [7:0] d, input int n, input int pm, input logic stop);
		logic [9:0] f;
		logic p;
		f = 10'(d & 8'((1 << n) - 1));
		p = ^f;
		if (pm == 2)
			p = ~p;
		if (pm == 3)
			p = 1'b1;
		if (pm == 4)
			p = 1'b0;
		if (pm != 0)
			f[n] = p;
		f[n + int'(pm != 0)] = stop;
		return f;
	endfunction

	task automatic wait_rx(input int k);
		for (int i = 0; i < 5000 && u_peer.rx_q.size() < k; i++)
			@(posedge i_sys_clk);
	endtask

	task automatic txchk(input logic [7:0] d, input int n, input int pm);
		wait_rx(1);
		w = '1;
		if (u_peer.rx_q.size() > 0)
			w = u_peer.rx_q.pop_front();
		chk(32'(w), 32'(frame(d, n, pm, 1'b1)), "tx frame");
	endtask

	task automatic cfg(input logic [7:0] lcr, input int n, input int pe);
		wr(`OFF_CTL, 32'h300);
		wr(`OFF_IBRD, 32'h1);
		wr(`OFF_FBRD, 32'h0);
		wr(`OFF_LCR, 32'(lcr));
		wr(`OFF_CTL, 32'h301);
		u_peer.nbits = n;
		u_peer.par_en = pe;
	endtask

	task automatic gap(input int lo, input int hi);
		dc = int'((u_peer.fall_q[1] - u_peer.fall_q[0]) / 25.0);
		chk(32'(dc >= lo && dc <= hi), 32'h1, "start spacing");
	endtask

	initial
	begin
		cyc(20);
		i_rstn <= 1'b1;
		@(posedge i_sys_clk);
		rc(`OFF_CTL, 32'h300, "control reset");
		rc(`OFF_LCR, 32'h0, "line control reset");
		rc(`OFF_LVL, 32'h12, "level reset");
		rc(`OFF_FLAG, 32'h90, "flag reset");
		rc(8'h08, 32'h0, "unmapped read");
		$display("test reset done");
		for (int n = 5; n <= 8; n++)
			for (int pm = 0; pm < 5; pm++)
			begin
				cfg(par_lcr[pm] | 8'((n - 5) << 5), n, int'(pm != 0));
				wr(`OFF_DATA, 32'(8'hb5 ^ 8'(n)));
				txchk(8'hb5 ^ 8'(n), n, pm);
				u_peer.send(frame(8'h4e + 8'(n), n, pm, 1'b1), n + int'(pm != 0) + 1);
				rc(`OFF_DATA, 32'(8'h4e + 8'(n) & 8'((1 << n) - 1)), "rx char");
			end
		$display("test formats done");
		cfg(8'h66, 8, 1);
		w = frame(8'h3c, 8, 1, 1'b1);
		w[8] = ~w[8];
		u_peer.send(w, 10);
		rc(`OFF_DATA, 32'h23c, "parity error");
		u_peer.send(frame(8'h3c, 8, 1, 1'b0), 10);
		rc(`OFF_DATA, 32'h13c, "framing error");
		u_peer.send(10'h0, 10);
		rc(`OFF_DATA, 32'h500, "break");
		rc(`OFF_RSR, 32'h7, "status flags");
		wr(`OFF_RSR, 32'h0);
		u_peer.glitch(4);
		cyc(40);
		rc(`OFF_RSR, 32'h10, "false start");
		rc(`OFF_FLAG, 32'h90, "no char stored");
		wr(`OFF_RSR, 32'h0);
		u_peer.send(frame(8'h61, 8, 1, 1'b1), 10);
		u_peer.send(frame(8'h62, 8, 1, 1'b1), 10);
		rc(`OFF_RSR, 32'h8, "overrun");
		rc(`OFF_DATA, 32'h61, "single entry");
		u_peer.send(frame(8'h63, 8, 1, 1'b1), 10);
		rc(`OFF_DATA, 32'h863, "overrun carried");
		rc(`OFF_DATA, 32'h0, "empty read");
		$display("test receive errors done");
		cfg(8'h68, 8, 0);
		u_peer.fall_q.delete();
		wr(`OFF_DATA, 32'h81);
		cyc(1);
		wr(`OFF_DATA, 32'h7e);
		cyc(2);
		chk(32'(o_busy), 32'h1, "busy set");
		wait_rx(2);
		chk(32'(o_busy), 32'h1, "busy during stop");
		txchk(8'h81, 8, 0);
		txchk(8'h7e, 8, 0);
		gap(175, 177);
		cyc(40);
		chk(32'(o_busy), 32'h0, "busy clear");
		$display("test two stop done");
		cfg(8'h60, 8, 0);
		wr(`OFF_CTL, 32'h201);
		wr(`OFF_DATA, 32'h11);
		cyc(300);
		chk(32'(u_peer.rx_q.size()), 32'h0, "tx gated");
		chk(32'(o_busy), 32'h1, "busy while gated");
		wr(`OFF_CTL, 32'h101);
		u_peer.send(frame(8'h22, 8, 0, 1'b1), 9);
		rc(`OFF_DATA, 32'h0, "rx gated");
		txchk(8'h11, 8, 0);
		$display("test enables done");
		cfg(8'h70, 8, 0);
		wr(`OFF_DATA, 32'hc3);
		wr(`OFF_DATA, 32'h3c);
		cyc(40);
		wr(`OFF_CTL, 32'h300);
		txchk(8'hc3, 8, 0);
		cyc(200);
		chk(32'(u_peer.rx_q.size()), 32'h0, "stopped");
		chk(32'(o_busy), 32'h1, "busy while disabled");
		wr(`OFF_CTL, 32'h301);
		txchk(8'h3c, 8, 0);
		$display("test disable done");
		wr(`OFF_CTL, 32'h300);
		wr(`OFF_LVL, 32'h0);
		for (int i = 0; i < 17; i++)
			wr(`OFF_DATA, 32'(8'h10 + 8'(i)));
		cyc(2);
		rc(`OFF_FLAG, 32'h38, "tx full");
		chk(32'(o_tx_level_hit), 32'h0, "tx level");
		wr(`OFF_CTL, 32'h301);
		for (int i = 0; i < 16; i++)
			txchk(8'h10 + 8'(i), 8, 0);
		cyc(200);
		chk(32'(u_peer.rx_q.size()), 32'h0, "dropped write");
		chk(32'(o_tx_level_hit), 32'h1, "tx level empty");
		wr(`OFF_RSR, 32'h0);
		for (int i = 0; i < 17; i++)
			u_peer.send(frame(8'h40 + 8'(i), 8, 0, 1'b1), 9);
		rc(`OFF_FLAG, 32'hc0, "rx full");
		for (int c = 16; c > 0; c--)
		begin
			for (int k = 0; k < 5; k++)
			begin
				wr(`OFF_LVL, 32'(k << 3));
				cyc(2);
				chk(32'(o_rx_level_hit), 32'(c >= thr[k]), "rx level");
			end
			rc(`OFF_DATA, 32'(8'h50 - 8'(c)), "rx order");
		end
		rc(`OFF_RSR, 32'h8, "rx overrun");
		$display("test fifos done");
		wr(`OFF_LCR, 32'h71);
		cyc(40);
		chk(32'(o_serial_out), 32'h0, "break sent");
		wr(`OFF_LCR, 32'h70);
		cyc(300);
		chk(32'(o_serial_out), 32'h1, "break ended");
		wr(`OFF_CTL, 32'h300);
		wr(`OFF_IBRD, 32'h2);
		wr(`OFF_FBRD, 32'h20);
		wr(`OFF_LCR, 32'h60);
		wr(`OFF_IBRD, 32'h3);
		wr(`OFF_CTL, 32'h301);
		u_peer.bit_clk = 40;
		u_peer.rx_q.delete();
		u_peer.fall_q.delete();
		wr(`OFF_DATA, 32'h96);
		cyc(1);
		wr(`OFF_DATA, 32'h69);
		wait_rx(2);
		txchk(8'h96, 8, 0);
		txchk(8'h69, 8, 0);
		gap(397, 403);
		$display("test fractional divisor done");
		end_of_test();
	end
endmodule
